// [include/freq_measure_pkg.sv]
`default_nettype none

package freq_measure_pkg;

  // Clock and on-board timebase rates
  localparam int CLK_HZ      = 50_000_000;
  localparam int TB_FAST_HZ  = 80_000_000;
  localparam int TB_MID_HZ   = 20_000_000;
  localparam int TB_SLOW_HZ  = 100_000;
  localparam int TB_SLOW_DIV = CLK_HZ / TB_SLOW_HZ;

  // Register map, byte addresses
  localparam logic [7:0] CTR_STRIDE  = 8'h10;
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_DIVN    = 8'h04;
  localparam logic [7:0] OFS_DATA0   = 8'h08;
  localparam logic [7:0] OFS_DATA1   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h40;
  localparam logic [7:0] ADDR_CLEAR  = 8'h44;
  localparam logic [7:0] ADDR_ENABLE = 8'h48;

  // Control register fields
  localparam int CFG_W          = 9;
  localparam int CTRL_ARM_BIT   = 9;
  localparam int CTRL_STATE_LSB = 12;
  localparam logic [CFG_W-1:0] CTRL_RESET = 9'h100;

  // Source selections
  localparam logic [1:0] SRC_PIN  = 2'h0;
  localparam logic [1:0] SRC_FAST = 2'h1;
  localparam logic [1:0] SRC_MID  = 2'h2;
  localparam logic [1:0] SRC_SLOW = 2'h3;

  // Gate selections
  localparam logic [1:0] GATE_PIN     = 2'h0;
  localparam logic [1:0] GATE_PFT     = 2'h1;
  localparam logic [1:0] GATE_PARTNER = 2'h2;

  typedef enum logic [2:0] {
    MODE_IDLE        = 3'h0,
    MODE_PERIOD      = 3'h1,
    MODE_PULSE_WIDTH = 3'h2,
    MODE_DIVIDE      = 3'h3,
    MODE_SAMPLED     = 3'h4
  } mode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_RUN  = 2'h3,
    ST_DONE = 2'h2
  } state_t;

  typedef struct packed {
    logic       averaging_enable;
    logic       falling;
    logic [1:0] gate_sel;
    logic [1:0] src_sel;
    mode_t      mode;
  } cfg_t;

endpackage : freq_measure_pkg

`default_nettype wire

// [verilog/freq_measure_counter.sv]
`timescale 1ns/1ps
`default_nettype none

module freq_measure_counter #(
  parameter int NUM_CTR = 4,
  parameter int CNT_W   = 32
) (
  // Clock and reset
  input  wire logic               SYS_CLK,
  input  wire logic               SRST,
  // APB slave
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [7:0]         PADDR,
  input  wire logic [31:0]        PWDATA,
  output var  logic [31:0]        PRDATA,
  output var  logic               PREADY,
  output var  logic               PSLVERR,
  // Signal pins
  input  wire logic [NUM_CTR-1:0] SRC_IN,
  input  wire logic [NUM_CTR-1:0] GATE_IN,
  input  wire logic [NUM_CTR-1:0] PROGRAMMABLE_FUNCTION_TERMINAL,
  input  wire logic               TB_FAST_IN,
  input  wire logic               TB_MID_IN,
  input  wire logic               SAMPLE_CLK_IN,
  // Outputs
  output var  logic [NUM_CTR-1:0] CTR_OUT,
  output var  logic               IRQ
);

  localparam int SW = 3 * NUM_CTR + 3;

  // Elaboration check: map holds two or four counters
  if (!(NUM_CTR == 2 || NUM_CTR == 4) || CNT_W < 8 || CNT_W > 32) begin : g_chk
    $error("freq_measure_counter: unsupported NUM_CTR or CNT_W");
  end

  // Three-stage synchronisers; level moves when stages two and three agree
  logic [SW-1:0] s1_r, s2_r, s3_r, lvl_r, lvl_d_r, lvl_nxt, rise;
  always_comb begin
    lvl_nxt = (s3_r & ~(s2_r ^ s3_r)) | (lvl_r & (s2_r ^ s3_r));
  end
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
      lvl_d_r <= '0;
    end else begin
      s1_r <= {SAMPLE_CLK_IN, TB_MID_IN, TB_FAST_IN,
               PROGRAMMABLE_FUNCTION_TERMINAL, GATE_IN, SRC_IN};
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
      lvl_d_r <= lvl_r;
    end
  end
  assign rise = lvl_r & ~lvl_d_r;

  // 100 kHz timebase as a one-cycle enable
  logic [15:0] slow_cnt_r;
  logic        slow_tick_r;
  always_ff @(posedge SYS_CLK) begin
    if (SRST || slow_cnt_r == 16'(freq_measure_pkg::TB_SLOW_DIV - 1)) begin
      slow_cnt_r <= '0;
      slow_tick_r <= !SRST;
    end else begin
      slow_cnt_r <= slow_cnt_r + 16'h0001;
      slow_tick_r <= 1'b0;
    end
  end

  wire smp_ev = rise[SW-1];

  // APB decode; a write takes effect at the edge that sees pready, read data is taken one edge earlier
  logic       pready_r, pslverr_r;
  logic [31:0] prdata_r, rdata_nxt;
  logic       mapped;
  wire        acc   = PSEL & PENABLE & pready_r;
  wire        wr    = acc & PWRITE;
  wire [1:0]  ridx  = PADDR[5:4];
  wire [7:0]  rofs  = {4'h0, PADDR[3:0]};
  wire        in_ctr = PADDR < (freq_measure_pkg::CTR_STRIDE * 8'(NUM_CTR));

  freq_measure_pkg::cfg_t   cfg_r   [NUM_CTR];
  freq_measure_pkg::state_t st_r    [NUM_CTR];
  logic [CNT_W-1:0]         divn_r  [NUM_CTR];
  logic [CNT_W-1:0]         d0_r    [NUM_CTR];
  logic [CNT_W-1:0]         d1_r    [NUM_CTR];
  logic [NUM_CTR-1:0]       cap_p, ovr_p, out_r;
  logic [2*NUM_CTR-1:0]     stat_r, en_r, stat_nxt;

  // Register read mux and unmapped detection
  always_comb begin
    rdata_nxt = '0;
    mapped = (PADDR[1:0] == 2'h0);
    if (in_ctr) begin
      case (rofs)
        freq_measure_pkg::OFS_CTRL: begin
          rdata_nxt[freq_measure_pkg::CFG_W-1:0] = cfg_r[ridx];
          rdata_nxt[freq_measure_pkg::CTRL_STATE_LSB +: 2] = st_r[ridx];
        end
        freq_measure_pkg::OFS_DIVN:  rdata_nxt[CNT_W-1:0] = divn_r[ridx];
        freq_measure_pkg::OFS_DATA0: rdata_nxt[CNT_W-1:0] = d0_r[ridx];
        freq_measure_pkg::OFS_DATA1: rdata_nxt[CNT_W-1:0] = d1_r[ridx];
        default: mapped = 1'b0;
      endcase
    end else begin
      case (PADDR)
        freq_measure_pkg::ADDR_STATUS: rdata_nxt[2*NUM_CTR-1:0] = stat_r;
        freq_measure_pkg::ADDR_CLEAR:  rdata_nxt = '0;
        freq_measure_pkg::ADDR_ENABLE: rdata_nxt[2*NUM_CTR-1:0] = en_r;
        default: mapped = 1'b0;
      endcase
    end
  end

  // One wait state, so every access answers in the second access cycle
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= PSEL & PENABLE & ~pready_r;
      pslverr_r <= PSEL & PENABLE & ~pready_r & ~mapped;
      prdata_r <= (PSEL & PENABLE & ~pready_r & ~PWRITE) ? rdata_nxt : '0;
    end
  end
  assign PREADY  = pready_r;
  assign PSLVERR = pslverr_r;
  assign PRDATA  = prdata_r;

  // Sticky status; an event in the clearing cycle still sets its bit
  always_comb begin
    stat_nxt = stat_r | {ovr_p, cap_p};
    if (wr && PADDR == freq_measure_pkg::ADDR_CLEAR) begin
      stat_nxt = (stat_r & ~PWDATA[2*NUM_CTR-1:0]) | {ovr_p, cap_p};
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      stat_r <= '0;
      en_r <= '0;
      IRQ <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      if (wr && PADDR == freq_measure_pkg::ADDR_ENABLE) begin
        en_r <= PWDATA[2*NUM_CTR-1:0];
      end
      IRQ <= |(stat_nxt & en_r);
    end
  end

  assign CTR_OUT = out_r;

  // Per-counter measurement engines
  for (genvar i = 0; i < NUM_CTR; i++) begin : g_ctr
    localparam int PARTNER = i ^ 1;
    logic             src_ev, g_lvl, g_act, g_d_r, g_rise, g_fall;
    logic [CNT_W-1:0] cnt_r, emb_r, last_r;
    logic             have_r;
    wire              sel = in_ctr && ridx == 2'(i);
    wire              wr_ctrl = wr && sel && rofs == freq_measure_pkg::OFS_CTRL;
    wire              wr_divn = wr && sel && rofs == freq_measure_pkg::OFS_DIVN;
    wire [CNT_W-1:0]  cnt_inc = cnt_r + CNT_W'(1);
    wire [CNT_W-1:0]  src_one = CNT_W'(src_ev);

    // Source and gate routing
    always_comb begin
      case (cfg_r[i].src_sel)
        freq_measure_pkg::SRC_FAST: src_ev = rise[3*NUM_CTR];
        freq_measure_pkg::SRC_MID:  src_ev = rise[3*NUM_CTR+1];
        freq_measure_pkg::SRC_SLOW: src_ev = slow_tick_r;
        default:                    src_ev = rise[i];
      endcase
      case (cfg_r[i].gate_sel)
        freq_measure_pkg::GATE_PFT:     g_lvl = lvl_r[2*NUM_CTR+i];
        freq_measure_pkg::GATE_PARTNER: g_lvl = out_r[PARTNER];
        default:                        g_lvl = lvl_r[NUM_CTR+i];
      endcase
      g_act = g_lvl ^ cfg_r[i].falling;
    end
    assign g_rise = g_act & ~g_d_r;
    assign g_fall = ~g_act & g_d_r;

    // Configuration; an arm marks the gate active, so a polarity change is no edge
    always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
        cfg_r[i] <= freq_measure_pkg::CTRL_RESET;
        divn_r[i] <= CNT_W'(1);
        g_d_r <= 1'b0;
      end else begin
        if (wr_ctrl) cfg_r[i] <= PWDATA[freq_measure_pkg::CFG_W-1:0];
        if (wr_divn) divn_r[i] <= PWDATA[CNT_W-1:0];
        g_d_r <= g_act | wr_ctrl;
      end
    end

    // Measurement state machine; a control write re-arms or stops it
    always_ff @(posedge SYS_CLK) begin
      cap_p[i] <= 1'b0;
      ovr_p[i] <= 1'b0;
      if (SRST) begin
        st_r[i] <= freq_measure_pkg::ST_IDLE;
        cnt_r <= '0;
        emb_r <= '0;
        last_r <= '0;
        have_r <= 1'b0;
        out_r[i] <= 1'b0;
        d0_r[i] <= '0;
        d1_r[i] <= '0;
      end else if (wr_ctrl) begin
        cnt_r <= '0;
        emb_r <= '0;
        have_r <= 1'b0;
        out_r[i] <= 1'b0;
        if (!PWDATA[freq_measure_pkg::CTRL_ARM_BIT]) begin
          st_r[i] <= freq_measure_pkg::ST_IDLE;
        end else if (PWDATA[2:0] == freq_measure_pkg::MODE_SAMPLED) begin
          st_r[i] <= freq_measure_pkg::ST_RUN;
        end else begin
          st_r[i] <= freq_measure_pkg::ST_WAIT;
        end
      end else begin
        case (st_r[i])
          freq_measure_pkg::ST_WAIT: begin
            if (cfg_r[i].mode == freq_measure_pkg::MODE_DIVIDE) begin
              if (src_ev) begin
                out_r[i] <= 1'b1;
                st_r[i] <= freq_measure_pkg::ST_RUN;
              end
            end else if (g_rise) begin
              cnt_r <= src_one;
              st_r[i] <= freq_measure_pkg::ST_RUN;
            end
          end
          freq_measure_pkg::ST_RUN: begin
            case (cfg_r[i].mode)
              freq_measure_pkg::MODE_PERIOD: begin
                if (g_rise) begin
                  d0_r[i] <= cnt_r;
                  cap_p[i] <= 1'b1;
                  st_r[i] <= freq_measure_pkg::ST_DONE;
                end else if (src_ev) begin
                  cnt_r <= cnt_inc;
                end
              end
              freq_measure_pkg::MODE_PULSE_WIDTH: begin
                if (g_fall) begin
                  d0_r[i] <= cnt_r;
                  cap_p[i] <= 1'b1;
                  st_r[i] <= freq_measure_pkg::ST_DONE;
                end else if (src_ev) begin
                  cnt_r <= cnt_inc;
                end
              end
              freq_measure_pkg::MODE_DIVIDE: begin
                if (src_ev) begin
                  if (cnt_inc >= divn_r[i]) begin
                    out_r[i] <= 1'b0;
                    st_r[i] <= freq_measure_pkg::ST_DONE;
                  end else begin
                    cnt_r <= cnt_inc;
                  end
                end
              end
              freq_measure_pkg::MODE_SAMPLED: begin
                if (cfg_r[i].averaging_enable) begin
                  if (smp_ev) begin
                    d0_r[i] <= emb_r;
                    d1_r[i] <= cnt_r;
                    cap_p[i] <= 1'b1;
                    emb_r <= CNT_W'(g_rise);
                    cnt_r <= src_one;
                  end else begin
                    if (g_rise) emb_r <= emb_r + CNT_W'(1);
                    if (src_ev) cnt_r <= cnt_inc;
                  end
                end else begin
                  // Period between active gate edges, in source ticks
                  if (g_rise) begin
                    if (emb_r != '0) begin
                      last_r <= cnt_r;
                      have_r <= ~smp_ev;
                    end
                    emb_r <= CNT_W'(1);
                    cnt_r <= src_one;
                  end else if (src_ev) begin
                    cnt_r <= cnt_inc;
                  end
                  if (smp_ev) begin
                    d1_r[i] <= '0;
                    if (g_rise && emb_r != '0) begin
                      d0_r[i] <= cnt_r;
                      cap_p[i] <= 1'b1;
                    end else if (have_r) begin
                      d0_r[i] <= last_r;
                      cap_p[i] <= 1'b1;
                    end else begin
                      ovr_p[i] <= 1'b1;
                    end
                    if (!g_rise) have_r <= 1'b0;
                  end
                end
              end
              default: st_r[i] <= freq_measure_pkg::ST_IDLE;
            endcase
          end
          default: ;  // Idle or done: edges ignored until re-armed
        endcase
      end
    end
  end

endmodule : freq_measure_counter

`default_nettype wire

// [sim/fm_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module fm_monitor #(
  parameter int NUM_CTR = 4
) (
  // Clock and reset
  input wire logic               SYS_CLK,
  input wire logic               SRST,
  // APB
  input wire logic               PSEL,
  input wire logic               PENABLE,
  input wire logic               PWRITE,
  input wire logic [7:0]         PADDR,
  input wire logic [31:0]        PWDATA,
  input wire logic [31:0]        PRDATA,
  input wire logic               PREADY,
  input wire logic               PSLVERR,
  // Outputs
  input wire logic [NUM_CTR-1:0] CTR_OUT,
  input wire logic               IRQ
);
  logic [31:0] en_r;

  // Shadow of the interrupt enable, taken only on accepted writes
  always_ff @(posedge SYS_CLK) begin
    if (SRST)
      en_r <= 32'h0;
    else if (PSEL && PENABLE && PREADY && PWRITE &&
             PADDR == freq_measure_pkg::ADDR_ENABLE)
      en_r <= PWDATA;
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);

  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready held over one cycle");
  wait_state_a: assert property ($rose(PENABLE) && PSEL |-> !PREADY ##1 PREADY)
    else $error("ready not in second access cycle");
  ready_req_a: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready without request");
  rdata_idle_a: assert property (!PREADY || PWRITE |-> PRDATA == 32'h0)
    else $error("read data outside read answer");
  err_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  bad_addr_a: assert property (PREADY && PADDR[1:0] != 2'h0 |-> PSLVERR)
    else $error("unaligned access not refused");
  status_ok_a: assert property (
    PREADY && PADDR == freq_measure_pkg::ADDR_STATUS |-> !PSLVERR)
    else $error("status access refused");
  irq_enable_a: assert property (IRQ |-> en_r != 32'h0 || $past(en_r) != 32'h0)
    else $error("interrupt with nothing enabled");
  reset_quiet_a: assert property (disable iff (1'b0)
    SRST |=> !PREADY && !IRQ && CTR_OUT == '0)
    else $error("outputs active after reset");
endmodule : fm_monitor
`default_nettype wire

// [sim/sig_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module sig_partner #(
  parameter int SRC_HALF  = 4,
  parameter int GATE_HALF = 40
) (
  // Clock and gate run control
  input wire logic SYS_CLK,
  input wire logic run,
  // Waves
  output var logic src,
  output var logic gate,
  output var logic fast
);
  int sc = 0;
  int gc = 0;
  int fc = 0;

  // Timebases run free; the unknown gate stops when run is low
  always @(posedge SYS_CLK) begin
    sc <= (sc == 2*SRC_HALF-1) ? 0 : sc + 1;
    fc <= (fc == 5) ? 0 : fc + 1;
    src <= sc < SRC_HALF;
    fast <= fc < 3;
    if (run)
      gc <= (gc == 2*GATE_HALF-1) ? 0 : gc + 1;
    gate <= gc < GATE_HALF;
  end
endmodule : sig_partner
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int SP = 8;
  localparam int GP = 80;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  pa = 8'h0;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic [31:0] rd;
  logic        prdy, perr, rerr, src, gate, fast, irq, samp;
  logic        run = 1'b1;
  logic        samp_en = 1'b0;
  logic [3:0]  cout;
  logic [8:0]  scnt = 9'h0;
  int          errors = 0;
  int          total_checks = 0;
  int          hi;
  int          model_q[$];

  initial begin
    forever #10 clk = ~clk;
  end
  // Sample clock every 400 cycles, high 4 cycles to pass the synchroniser
  always @(posedge clk) begin
    scnt <= (scnt == 9'h18f) ? 9'h0 : scnt + 9'h1;
  end
  assign samp = samp_en && scnt < 9'h4;

  sig_partner #(.SRC_HALF(SP/2), .GATE_HALF(GP/2)) PARTNER (.SYS_CLK(clk),
    .run(run), .src(src), .gate(gate), .fast(fast));
  freq_measure_counter DUT (.SYS_CLK(clk), .SRST(rst), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
    .PREADY(prdy), .PSLVERR(perr), .SRC_IN({4{src}}), .GATE_IN({4{gate}}),
    .PROGRAMMABLE_FUNCTION_TERMINAL({4{gate}}), .TB_FAST_IN(src),
    .TB_MID_IN(fast), .SAMPLE_CLK_IN(samp), .CTR_OUT(cout), .IRQ(irq));

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk) pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    rd = prd;
    rerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (prdy !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
  endtask : apb

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(s, e, rd);
  endtask : rchk

  // Model: whole source periods inside a window that opens on a source edge
  function automatic int ticks(input int span, input int per);
    return span / per;
  endfunction : ticks

  // Compare a count register with the model's oldest pending result
  task automatic mchk(input string s, input logic [7:0] a);
    int e;
    e = (model_q.size() > 0) ? model_q.pop_front() : -1;
    rchk(s, a, e);
  endtask : mchk

  // Poll status until a bit sets; bounded so a dead counter ends the run
  task automatic wcap(input int b);
    int n = 0;
    do begin
      apb(1'b0, freq_measure_pkg::ADDR_STATUS, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 400);
    if (rd[b] !== 1'b1) begin
      errors++;
      tally_and_finish();
    end
  endtask : wcap

  function automatic logic [31:0] cw(input freq_measure_pkg::mode_t m,
    input logic [1:0] s, input logic [1:0] g, input logic f, input logic v);
    freq_measure_pkg::cfg_t c;
    c = '{averaging_enable: v, falling: f, gate_sel: g, src_sel: s, mode: m};
    return {22'h0, 1'b1, c};
  endfunction : cw

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  initial begin
    void'($urandom(78));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rchk("ctrl", 8'h00, {23'h0, freq_measure_pkg::CTRL_RESET});
    rchk("divn", 8'h04, 32'h1);
    rchk("status", freq_measure_pkg::ADDR_STATUS, 32'h0);
    apb(1'b0, 8'h4d, 32'h0);
    chk("refused", 32'h1, {31'h0, rerr});
    chk("refused data", 32'h0, rd);
    // Period, both edges, armed at a random phase
    for (int f = 0; f < 2; f++) begin
      repeat ($urandom % GP) @(posedge clk);
      apb(1'b1, 8'h00, cw(freq_measure_pkg::MODE_PERIOD, 2'h0, 2'h0, f[0],
        1'b1));
      model_q.push_back(ticks(GP, SP));
      wcap(0);
      mchk("period", 8'h08);
      apb(1'b1, freq_measure_pkg::ADDR_CLEAR, 32'h1);
    end
    // Pulse width on counter 3 from gate pin, then function terminal
    for (int g = 0; g < 2; g++) begin
      repeat ($urandom % GP) @(posedge clk);
      apb(1'b1, 8'h30, cw(freq_measure_pkg::MODE_PULSE_WIDTH, 2'h0, g[1:0],
        1'b0, 1'b1));
      model_q.push_back(ticks(GP/2, SP));
      model_q.push_back(ticks(GP/2, SP));
      wcap(3);
      mchk("width", 8'h38);
      apb(1'b1, freq_measure_pkg::ADDR_CLEAR, 32'h8);
      repeat (200) @(posedge clk);
      rchk("ignored", freq_measure_pkg::ADDR_STATUS, 32'h0);
      mchk("held", 8'h38);
    end
    // Counter 0 divides by 3, partner counter 1 times it on 6-cycle ticks
    apb(1'b1, 8'h04, 32'h3);
    apb(1'b1, 8'h10, cw(freq_measure_pkg::MODE_PULSE_WIDTH, 2'h2, 2'h2, 1'b0,
      1'b1));
    apb(1'b1, 8'h00, cw(freq_measure_pkg::MODE_DIVIDE, 2'h0, 2'h0, 1'b0,
      1'b1));
    model_q.push_back(ticks(3*SP, 6));
    for (hi = 0; hi < 500 && cout[0] !== 1'b1; hi++) @(posedge clk);
    for (hi = 0; hi < 500 && cout[0] === 1'b1; hi++) @(posedge clk);
    chk("divide", 3*SP, hi);
    wcap(1);
    mchk("partner", 8'h18);
    // Counter 2 divides the 100 kHz tick by 2; counter 3 times it on the
    // fast timebase pin, which carries the source wave here
    apb(1'b1, 8'h24, 32'h2);
    apb(1'b1, 8'h30, cw(freq_measure_pkg::MODE_PULSE_WIDTH, 2'h1, 2'h2, 1'b0,
      1'b1));
    apb(1'b1, 8'h20, cw(freq_measure_pkg::MODE_DIVIDE, 2'h3, 2'h0, 1'b0,
      1'b1));
    model_q.push_back(ticks(2*freq_measure_pkg::TB_SLOW_DIV, SP));
    for (hi = 0; hi < 1200 && cout[2] !== 1'b1; hi++) @(posedge clk);
    for (hi = 0; hi < 1200 && cout[2] === 1'b1; hi++) @(posedge clk);
    chk("slow divide", 2*freq_measure_pkg::TB_SLOW_DIV, hi);
    wcap(3);
    mchk("slow partner", 8'h38);
    // Sampled on counter 2: averaging, then last period only
    samp_en <= 1'b1;
    apb(1'b1, 8'h20, cw(freq_measure_pkg::MODE_SAMPLED, 2'h0, 2'h0, 1'b0,
      1'b1));
    wcap(2);
    apb(1'b1, freq_measure_pkg::ADDR_CLEAR, 32'h4);
    model_q.push_back(ticks(400, GP));
    model_q.push_back(ticks(400, SP));
    wcap(2);
    mchk("fx", 8'h28);
    mchk("fk", 8'h2c);
    apb(1'b1, 8'h20, cw(freq_measure_pkg::MODE_SAMPLED, 2'h0, 2'h0, 1'b0,
      1'b0));
    apb(1'b1, freq_measure_pkg::ADDR_CLEAR, 32'h4);
    model_q.push_back(ticks(GP, SP));
    wcap(2);
    mchk("last", 8'h28);
    // Re-arm may leave an overrun pending; start the stop test clean
    apb(1'b1, freq_measure_pkg::ADDR_CLEAR, 32'h40);
    // Stopped gate: overrun, masked, enabled, cleared
    run <= 1'b0;
    wcap(6);
    chk("masked", 32'h0, {31'h0, irq});
    apb(1'b1, freq_measure_pkg::ADDR_ENABLE, 32'h40);
    repeat (3) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, freq_measure_pkg::ADDR_CLEAR, 32'h40);
    repeat (3) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    tally_and_finish();
  end
endmodule : tb

bind freq_measure_counter fm_monitor #(.NUM_CTR(NUM_CTR)) MON (
  .SYS_CLK(SYS_CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .CTR_OUT(CTR_OUT), .IRQ(IRQ));
`default_nettype wire
